// file: hw/sdrctl_regs.sv
// register tail of the sdram controller: dll status, high-speed option,
// write protection mode and violation status
// assumes a simple synchronous register port, one access per asserted strobe
`default_nettype none
`include "sdrctl_params.svh"
module sdrctl_regs (
    input  wire logic                 REF_CLK,
    input  wire logic                 ARST_N,
    input  wire sdrctl_pkg::sdrctl_req_s REQ,
    input  wire logic                 PHASE_LATE,
    input  wire logic                 PHASE_EARLY,
    output logic [31:0]               RDATA,
    output logic                      EARLY_READ_DISABLE,
    output logic [7:0]                MEM_DEVICE,
    output logic                      PROTECT_ENABLE
);
    import sdrctl_pkg::*;

    sdrctl_dll_s  dll;
    logic         hs_ff, nxt_hs;
    logic [7:0]   md_ff, nxt_md;
    logic         protect_enable_ff, nxt_protect_enable;
    logic         vflag_ff, nxt_vflag;
    logic [15:0]  vsrc_ff, nxt_vsrc;
    logic [31:0]  rdata_ff, nxt_rdata;
    logic         hit_dll, hit_hs, hit_wpmr, hit_wpsr, hit_md;
    logic         viol;

    ////////////////////////////////////////////////////////////////////////////
    // delay loop instance
    sdrctl_dll #(.WIDTH(`SDRCTL_DLL_WIDTH)) u_dll (
        .clk         (REF_CLK),
        .arst_n      (ARST_N),
        .phase_late  (PHASE_LATE),
        .phase_early (PHASE_EARLY),
        .inc         (dll.inc),
        .dec         (dll.dec),
        .ovf         (dll.ovf),
        .val         (dll.val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    assign hit_dll  = (REQ.addr == `SDRCTL_DLL_ADDR);
    assign hit_hs   = (REQ.addr == `SDRCTL_HS_ADDR);
    assign hit_wpmr = (REQ.addr == `SDRCTL_WPMR_ADDR);
    assign hit_wpsr = (REQ.addr == `SDRCTL_WPSR_ADDR);
    assign hit_md   = (REQ.addr == `SDRCTL_MD_ADDR);
    // a write to a guarded register while protection is on
    assign viol     = REQ.wr && protect_enable_ff && (hit_hs || hit_md);

    ////////////////////////////////////////////////////////////////////////////
    // writable state and violation capture
    always_comb begin
        nxt_hs    = hs_ff;
        nxt_md    = md_ff;
        nxt_protect_enable  = protect_enable_ff;
        nxt_vflag = vflag_ff;
        nxt_vsrc  = vsrc_ff;
        if (REQ.wr && !protect_enable_ff && hit_hs)
            nxt_hs = REQ.wdata[`SDRCTL_HS_EARLY_BIT];
        if (REQ.wr && !protect_enable_ff && hit_md)
            nxt_md = REQ.wdata[7:0];
        if (REQ.wr && hit_wpmr && REQ.wdata[31:`SDRCTL_WP_KEY_LSB] == `SDRCTL_WP_KEY)
            nxt_protect_enable = REQ.wdata[`SDRCTL_WP_EN_BIT];
        // read clears first; a violation in the same cycle wins so it is not lost
        if (REQ.rd && hit_wpsr) begin
            nxt_vflag = 1'b0;
            nxt_vsrc  = '0;
        end
        if (viol) begin
            nxt_vflag = 1'b1;
            nxt_vsrc  = REQ.addr[15:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hs_ff    <= `SDRCTL_HS_RESET;
            md_ff    <= `SDRCTL_MD_RESET;
            protect_enable_ff  <= 1'b0;
            vflag_ff <= 1'b0;
            vsrc_ff  <= '0;
        end else begin
            hs_ff    <= nxt_hs;
            md_ff    <= nxt_md;
            protect_enable_ff  <= nxt_protect_enable;
            vflag_ff <= nxt_vflag;
            vsrc_ff  <= nxt_vsrc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered read data, one cycle after the strobe; unmapped reads zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (REQ.rd) begin
            if (hit_dll) begin
                nxt_rdata[`SDRCTL_DLL_INC_BIT] = dll.inc;
                nxt_rdata[`SDRCTL_DLL_DEC_BIT] = dll.dec;
                nxt_rdata[`SDRCTL_DLL_OVF_BIT] = dll.ovf;
                nxt_rdata[15:`SDRCTL_DLL_VAL_LSB] = dll.val;
            end else if (hit_hs) begin
                nxt_rdata[`SDRCTL_HS_EARLY_BIT] = hs_ff;
            end else if (hit_wpmr) begin
                nxt_rdata[`SDRCTL_WP_EN_BIT] = protect_enable_ff; // key reads zero
            end else if (hit_wpsr) begin
                nxt_rdata[0] = vflag_ff;
                nxt_rdata[23:`SDRCTL_WPSR_SRC_LSB] = vsrc_ff;
            end else if (hit_md) begin
                nxt_rdata[7:0] = md_ff;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N)
            rdata_ff <= 32'h00000000;
        else
            rdata_ff <= nxt_rdata;
    end

    assign RDATA              = rdata_ff;
    assign EARLY_READ_DISABLE = hs_ff;
    assign MEM_DEVICE         = md_ff;
    assign PROTECT_ENABLE     = protect_enable_ff;
endmodule // sdrctl_regs
`default_nettype wire

// file: hw/sdrctl_params.svh
// constants for the sdram controller dll, high-speed and write-protect register tail
// assumes a 32-bit register port with byte addresses as printed
`ifndef SDRCTL_PARAMS_SVH
`define SDRCTL_PARAMS_SVH

`define SDRCTL_DLL_ADDR        32'hFFFFE824
`define SDRCTL_HS_ADDR         32'hFFFFE82C
`define SDRCTL_WPMR_ADDR       32'h0FFFE8E4
`define SDRCTL_WPSR_ADDR       32'h0FFFE8E8
`define SDRCTL_MD_ADDR         32'hFFFFE820

`define SDRCTL_DLL_INC_BIT     0
`define SDRCTL_DLL_DEC_BIT     1
`define SDRCTL_DLL_OVF_BIT     2
`define SDRCTL_DLL_VAL_LSB     8
`define SDRCTL_HS_EARLY_BIT    2
`define SDRCTL_WP_EN_BIT       0
`define SDRCTL_WP_KEY_LSB      8
`define SDRCTL_WP_KEY          24'h444452
`define SDRCTL_WPSR_SRC_LSB    8

`define SDRCTL_HS_RESET        1'b1
`define SDRCTL_MD_RESET        8'h10
`define SDRCTL_DLL_WIDTH       8
`define SDRCTL_DLL_LOCK_BAND   2

`endif

// file: hw/sdrctl_pkg.sv
// types shared by the sdram controller register tail
// assumes the params header sits on the include path
`default_nettype none
package sdrctl_pkg;
    // one register access from the peripheral bus
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sdrctl_req_s;

    // what the dll reports
    typedef struct packed {
        logic       inc;
        logic       dec;
        logic       ovf;
        logic [7:0] val;
    } sdrctl_dll_s;

    typedef enum logic [1:0] {
        SDRCTL_DLL_IDLE,
        SDRCTL_DLL_UP,
        SDRCTL_DLL_DOWN,
        SDRCTL_DLL_LOCKED
    } sdrctl_dll_e;
endpackage
`default_nettype wire

// file: hw/sdrctl_dll.sv
// master delay counter of the read-strobe delay loop
// assumes a phase detector reports early/late against the reference period
`default_nettype none
`include "sdrctl_params.svh"
module sdrctl_dll #(
    parameter int WIDTH = `SDRCTL_DLL_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             phase_late,
    input  wire logic             phase_early,
    output logic                  inc,
    output logic                  dec,
    output logic                  ovf,
    output logic [WIDTH-1:0]      val
);
    import sdrctl_pkg::*;

    sdrctl_dll_e       state_ff, nxt_state;
    logic [WIDTH-1:0]  val_ff, nxt_val;
    logic              ovf_ff, nxt_ovf;

    ////////////////////////////////////////////////////////////////////////////
    // counter walks toward the point where the strobe sits mid-window
    always_comb begin
        nxt_state = state_ff;
        nxt_val   = val_ff;
        nxt_ovf   = ovf_ff;
        unique case (state_ff)
            SDRCTL_DLL_IDLE, SDRCTL_DLL_UP, SDRCTL_DLL_DOWN: begin
                if (phase_late && !ovf_ff) begin
                    if (val_ff == {WIDTH{1'b1}}) begin
                        // line too short for this clock: stop and force lock
                        nxt_ovf   = 1'b1;
                        nxt_state = SDRCTL_DLL_LOCKED;
                    end else begin
                        nxt_val   = val_ff + 1'b1;
                        nxt_state = SDRCTL_DLL_UP;
                    end
                end else if (phase_early && val_ff != '0) begin
                    nxt_val   = val_ff - 1'b1;
                    nxt_state = SDRCTL_DLL_DOWN;
                end else begin
                    nxt_state = SDRCTL_DLL_LOCKED;
                end
            end
            SDRCTL_DLL_LOCKED: begin
                // relock only if drift appears and no overflow is pinned
                if (!ovf_ff && (phase_late || phase_early))
                    nxt_state = SDRCTL_DLL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SDRCTL_DLL_IDLE;
            val_ff   <= '0;
            ovf_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            val_ff   <= nxt_val;
            ovf_ff   <= nxt_ovf;
        end
    end

    assign inc = (state_ff == SDRCTL_DLL_UP);
    assign dec = (state_ff == SDRCTL_DLL_DOWN);
    assign ovf = ovf_ff;
    assign val = val_ff;
endmodule // sdrctl_dll
`default_nettype wire

// file: verification/sdrctl_regs_asserts.sv
// checker for the sdram controller register tail
// assumes it is bound onto sdrctl_regs and sees only its ports
`default_nettype none
`include "sdrctl_params.svh"
module sdrctl_regs_chk (
    input wire logic                    REF_CLK,
    input wire logic                    ARST_N,
    input wire sdrctl_pkg::sdrctl_req_s REQ,
    input wire logic                    PHASE_LATE,
    input wire logic                    PHASE_EARLY,
    input wire logic [31:0]             RDATA,
    input wire logic                    EARLY_READ_DISABLE,
    input wire logic [7:0]              MEM_DEVICE,
    input wire logic                    PROTECT_ENABLE
);
    import sdrctl_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // decoded strobes keep the properties short
    wire logic w_hs = REQ.wr && REQ.addr == `SDRCTL_HS_ADDR;
    wire logic w_md = REQ.wr && REQ.addr == `SDRCTL_MD_ADDR;
    wire logic w_wp = REQ.wr && REQ.addr == `SDRCTL_WPMR_ADDR;
    wire logic r_st = REQ.rd && REQ.addr == `SDRCTL_WPSR_ADDR;
    wire logic k_ok = REQ.wdata[31:8] == `SDRCTL_WP_KEY;
    ////////////////////////////////////////////////////////////////////////////
    property p_hs_wr; w_hs && !PROTECT_ENABLE |=> EARLY_READ_DISABLE == $past(REQ.wdata[2]); endproperty
    a_hs_wr: assert property (p_hs_wr) else $error("high-speed write lost");
    property p_hs_blk; w_hs && PROTECT_ENABLE |=> $stable(EARLY_READ_DISABLE); endproperty
    a_hs_blk: assert property (p_hs_blk) else $error("protected high-speed write taken");
    property p_md_wr; w_md && !PROTECT_ENABLE |=> MEM_DEVICE == $past(REQ.wdata[7:0]); endproperty
    a_md_wr: assert property (p_md_wr) else $error("device write lost");
    property p_md_blk; w_md && PROTECT_ENABLE |=> $stable(MEM_DEVICE); endproperty
    a_md_blk: assert property (p_md_blk) else $error("protected device write taken");
    property p_key_ok; w_wp && k_ok |=> PROTECT_ENABLE == $past(REQ.wdata[0]); endproperty
    a_key_ok: assert property (p_key_ok) else $error("keyed enable write lost");
    property p_key_bad; w_wp && !k_ok |=> $stable(PROTECT_ENABLE); endproperty
    a_key_bad: assert property (p_key_bad) else $error("bad key changed enable");
    property p_wp_rd; REQ.rd && REQ.addr == `SDRCTL_WPMR_ADDR |=> RDATA == {31'h0, PROTECT_ENABLE}; endproperty
    a_wp_rd: assert property (p_wp_rd) else $error("mode readback wrong");
    property p_viol; w_hs && PROTECT_ENABLE ##1 r_st |=> RDATA == 32'h00E8_2C01; endproperty
    a_viol: assert property (p_viol) else $error("violation status wrong");
    property p_rc; r_st ##1 r_st |=> RDATA == 32'h0; endproperty
    a_rc: assert property (p_rc) else $error("status not cleared by read");
    property p_idle; !REQ.rd |=> RDATA == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    // reserved bits of the loop status stay low whatever the counter does
    property p_dll; REQ.rd && REQ.addr == `SDRCTL_DLL_ADDR |=> RDATA[31:16] == 16'h0 && RDATA[7:3] == 5'h0;
    endproperty
    a_dll: assert property (p_dll) else $error("loop status reserved bits set");
endmodule // sdrctl_regs_chk
bind sdrctl_regs sdrctl_regs_chk sdrctl_regs_chk_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .REQ(REQ),
    .PHASE_LATE(PHASE_LATE), .PHASE_EARLY(PHASE_EARLY), .RDATA(RDATA),
    .EARLY_READ_DISABLE(EARLY_READ_DISABLE), .MEM_DEVICE(MEM_DEVICE), .PROTECT_ENABLE(PROTECT_ENABLE));
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the sdram controller register tail
// assumes sdrctl_regs with its checker bound in
`default_nettype none
`include "sdrctl_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sdrctl_pkg::*;
    logic        ref_clk = 1'b0;
    logic        arst_n  = 1'b0;
    sdrctl_req_s req     = '0;
    logic        late    = 1'b0;
    logic        early   = 1'b0;
    logic        rd_seen = 1'b0;
    logic [31:0] rdata;
    logic        erd;
    logic        pe;
    logic [7:0]  md;
    logic [23:0] key;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] pa[2] = '{`SDRCTL_HS_ADDR, `SDRCTL_MD_ADDR};
    int          n_errors = 0;
    int          samples_checked = 0;
    always #20 ref_clk = ~ref_clk;
    sdrctl_regs sdrctl_regs_i (.REF_CLK(ref_clk), .ARST_N(arst_n), .REQ(req), .PHASE_LATE(late),
        .PHASE_EARLY(early), .RDATA(rdata), .EARLY_READ_DISABLE(erd), .MEM_DEVICE(md), .PROTECT_ENABLE(pe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // one request per edge; the caller idles to release it
    task automatic acc(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{w, r, a, d};
    endtask
    task automatic idle();
        @(posedge ref_clk);
        req <= '0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        acc(1'b0, 1'b1, a, 32'h0);
    endtask
    task automatic print_verdict();
        // a read whose answer was never compared counts against the run
        n_errors += exp_q.size();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // read data is settled by the falling edge after the taking edge
    always @(posedge ref_clk) rd_seen <= req.rd;
    always @(negedge ref_clk) begin
        if (rd_seen) chk(rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    initial begin
        #(40 * 3000);
        n_errors++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(3));
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        idle();
        chk({erd, md, pe}, {1'b1, 8'h10, 1'b0});
        rd(`SDRCTL_WPSR_ADDR, 32'h0, '1);
        rd(32'h0000_0100, 32'h0, '1);
        idle();
        // early reads on; spreading buffers over banks stays with software
        acc(1'b1, 1'b0, `SDRCTL_HS_ADDR, 32'h0);
        idle();
        chk(erd, 1'b0);
        acc(1'b1, 1'b0, `SDRCTL_HS_ADDR, 32'h4);
        idle();
        chk(erd, 1'b1);
        $display("test reset and high-speed done");
        key = 24'($urandom);
        if (key == `SDRCTL_WP_KEY) key = 24'h0;
        acc(1'b1, 1'b0, `SDRCTL_WPMR_ADDR, {key, 8'h01});
        idle();
        chk(pe, 1'b0);
        acc(1'b1, 1'b0, `SDRCTL_WPMR_ADDR, {`SDRCTL_WP_KEY, 8'h01});
        rd(`SDRCTL_WPMR_ADDR, 32'h1, '1);
        idle();
        // each protected target on its own, then the status is read twice
        foreach (pa[i]) begin
            acc(1'b1, 1'b0, pa[i], {24'h0, 8'($urandom) & 8'hEB});
            rd(`SDRCTL_WPSR_ADDR, {8'h0, pa[i][15:0], 8'h01}, '1);
            rd(`SDRCTL_WPSR_ADDR, 32'h0, '1);
            idle();
        end
        chk({erd, md}, {1'b1, 8'h10});
        acc(1'b1, 1'b0, `SDRCTL_WPMR_ADDR, {`SDRCTL_WP_KEY, 8'h00});
        acc(1'b1, 1'b0, `SDRCTL_MD_ADDR, 32'h5);
        idle();
        chk({pe, md}, {1'b0, 8'h05});
        $display("test protection done");
        @(posedge ref_clk);
        late <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(`SDRCTL_DLL_ADDR, 32'h0000_0001, 32'hFFFF_00FF);
        idle();
        // long enough for the 8-bit counter to run into its ceiling
        repeat (600) @(posedge ref_clk);
        rd(`SDRCTL_DLL_ADDR, 32'h0000_FF04, '1);
        idle();
        // mid-run reset clears the pinned overflow and the counter
        @(posedge ref_clk);
        late   <= 1'b0;
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(`SDRCTL_DLL_ADDR, 32'h0, '1);
        idle();
        chk({erd, md, pe}, {1'b1, 8'h10, 1'b0});
        // count up a while, then back down so the decrement flag shows
        @(posedge ref_clk);
        late <= 1'b1;
        repeat (20) @(posedge ref_clk);
        late  <= 1'b0;
        early <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(`SDRCTL_DLL_ADDR, 32'h0000_0002, 32'hFFFF_00FF);
        idle();
        @(posedge ref_clk);
        early <= 1'b0;
        $display("test delay loop done");
        repeat (2) @(posedge ref_clk);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
